// ### shared/c8dec_pkg.sv
// constants, enumerations and register map of the cpu8 instruction decoder
package c8dec_pkg;
  localparam int ADDR_W = 16;
  // opcode rows (high nibble selects the addressing mode)
  localparam logic [3:0] HI_IMM = 4'ha;
  localparam logic [3:0] HI_DIR = 4'hb;
  localparam logic [3:0] HI_EXT = 4'hc;
  localparam logic [3:0] HI_IX2 = 4'hd;
  localparam logic [3:0] HI_IX1 = 4'he;
  localparam logic [3:0] HI_IX  = 4'hf;
  localparam logic [3:0] HI_BRBIT = 4'h0;
  localparam logic [3:0] HI_BIT   = 4'h1;
  localparam logic [3:0] HI_BRANCH = 4'h2;
  localparam logic [3:0] HI_SH_DIR = 4'h3;
  localparam logic [3:0] HI_SH_A   = 4'h4;
  localparam logic [3:0] HI_SH_X   = 4'h5;
  localparam logic [3:0] HI_SH_IX1 = 4'h6;
  localparam logic [3:0] HI_SH_IX  = 4'h7;
  localparam logic [3:0] LO_ADC = 4'h9;
  localparam logic [3:0] LO_AND = 4'h4;
  localparam logic [3:0] LO_SHL = 4'h8;
  localparam logic [7:0] OP_ACC_TO_INDEX = 8'h97;
  localparam logic [7:0] OP_INDEX_TO_ACC = 8'h9f;
  localparam logic [7:0] OP_HALT = 8'h8e;
  localparam logic [7:0] OP_IDLE = 8'h8f;
  // cycle counts
  localparam logic [2:0] CYC_RM_IMM = 3'h2;
  localparam logic [2:0] CYC_RM_DIR = 3'h3;
  localparam logic [2:0] CYC_RM_EXT = 3'h4;
  localparam logic [2:0] CYC_RM_IX2 = 3'h5;
  localparam logic [2:0] CYC_RM_IX1 = 3'h4;
  localparam logic [2:0] CYC_RM_IX  = 3'h3;
  localparam logic [2:0] CYC_SH_DIR = 3'h5;
  localparam logic [2:0] CYC_SH_REG = 3'h3;
  localparam logic [2:0] CYC_SH_IX1 = 3'h6;
  localparam logic [2:0] CYC_SH_IX  = 3'h5;
  localparam logic [2:0] CYC_BRANCH = 3'h3;
  localparam logic [2:0] CYC_BIT    = 3'h5;
  localparam logic [2:0] CYC_BRBIT  = 3'h5;
  localparam logic [2:0] CYC_SHORT  = 3'h2;
  // register map (byte addresses) and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PC   = 8'h04;
  localparam logic [7:0] REG_AX   = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_ILLEGAL_BIT = 8;
  localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    CL_NOP, CL_ADC, CL_AND, CL_SHL, CL_BRANCH, CL_BITSET, CL_BITCLR,
    CL_TSTSET, CL_TSTCLR, CL_ATOX, CL_XTOA, CL_HALT, CL_IDLE
  } c8dec_cls_t;
  typedef enum logic [3:0] {
    AM_NONE, AM_IMM, AM_DIR, AM_EXT, AM_IX2, AM_IX1, AM_IX, AM_INHA,
    AM_INHX, AM_REL
  } c8dec_mode_t;
  typedef enum logic [1:0] {ST_STOPPED, ST_RUN, ST_HALT, ST_IDLE}
    c8dec_state_t;
endpackage

// ### core/c8dec_decode.sv
// opcode decode: class, addressing mode, length and cycle count
`timescale 1ns/100ps
module c8dec_decode (
  input  wire logic [7:0]         opcode,
  output c8dec_pkg::c8dec_cls_t   cls,
  output c8dec_pkg::c8dec_mode_t  mode,
  output logic [1:0]              nbytes,
  output logic [2:0]              len,
  output logic                    rd_mem,
  output logic                    wr_mem,
  output logic                    legal
);
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];
  always_comb begin
    cls = c8dec_pkg::CL_NOP;
    mode = c8dec_pkg::AM_NONE;
    nbytes = 2'd1;
    len = c8dec_pkg::CYC_SHORT;
    rd_mem = 1'b0;
    wr_mem = 1'b0;
    legal = 1'b1;
    // rows 0-2 hold branch and bit opcodes whose low nibbles overlap these
    if ((lo == c8dec_pkg::LO_ADC || lo == c8dec_pkg::LO_AND)
        && hi > c8dec_pkg::HI_BRANCH) begin
      cls = (lo == c8dec_pkg::LO_ADC) ? c8dec_pkg::CL_ADC
                                      : c8dec_pkg::CL_AND;
      rd_mem = 1'b1;
      case (hi)
        c8dec_pkg::HI_IMM: begin
          mode = c8dec_pkg::AM_IMM; nbytes = 2'd2;
          len = c8dec_pkg::CYC_RM_IMM; rd_mem = 1'b0;
        end
        c8dec_pkg::HI_DIR: begin
          mode = c8dec_pkg::AM_DIR; nbytes = 2'd2;
          len = c8dec_pkg::CYC_RM_DIR;
        end
        c8dec_pkg::HI_EXT: begin
          mode = c8dec_pkg::AM_EXT; nbytes = 2'd3;
          len = c8dec_pkg::CYC_RM_EXT;
        end
        c8dec_pkg::HI_IX2: begin
          mode = c8dec_pkg::AM_IX2; nbytes = 2'd3;
          len = c8dec_pkg::CYC_RM_IX2;
        end
        c8dec_pkg::HI_IX1: begin
          mode = c8dec_pkg::AM_IX1; nbytes = 2'd2;
          len = c8dec_pkg::CYC_RM_IX1;
        end
        c8dec_pkg::HI_IX: begin
          mode = c8dec_pkg::AM_IX; len = c8dec_pkg::CYC_RM_IX;
        end
        default: begin
          cls = c8dec_pkg::CL_NOP; rd_mem = 1'b0; legal = 1'b0;
        end
      endcase
    end else if (lo == c8dec_pkg::LO_SHL && hi > c8dec_pkg::HI_BRANCH) begin
      cls = c8dec_pkg::CL_SHL;
      case (hi)
        c8dec_pkg::HI_SH_DIR: begin
          mode = c8dec_pkg::AM_DIR; nbytes = 2'd2; rd_mem = 1'b1;
          wr_mem = 1'b1; len = c8dec_pkg::CYC_SH_DIR;
        end
        c8dec_pkg::HI_SH_A: begin
          mode = c8dec_pkg::AM_INHA; len = c8dec_pkg::CYC_SH_REG;
        end
        c8dec_pkg::HI_SH_X: begin
          mode = c8dec_pkg::AM_INHX; len = c8dec_pkg::CYC_SH_REG;
        end
        c8dec_pkg::HI_SH_IX1: begin
          mode = c8dec_pkg::AM_IX1; nbytes = 2'd2; rd_mem = 1'b1;
          wr_mem = 1'b1; len = c8dec_pkg::CYC_SH_IX1;
        end
        c8dec_pkg::HI_SH_IX: begin
          mode = c8dec_pkg::AM_IX; rd_mem = 1'b1; wr_mem = 1'b1;
          len = c8dec_pkg::CYC_SH_IX;
        end
        default: begin
          cls = c8dec_pkg::CL_NOP; legal = 1'b0;
        end
      endcase
    end else if (hi == c8dec_pkg::HI_BRANCH) begin
      cls = c8dec_pkg::CL_BRANCH; mode = c8dec_pkg::AM_REL;
      nbytes = 2'd2; len = c8dec_pkg::CYC_BRANCH;
    end else if (hi == c8dec_pkg::HI_BIT) begin
      cls = opcode[0] ? c8dec_pkg::CL_BITCLR : c8dec_pkg::CL_BITSET;
      mode = c8dec_pkg::AM_DIR; nbytes = 2'd2; rd_mem = 1'b1;
      wr_mem = 1'b1; len = c8dec_pkg::CYC_BIT;
    end else if (hi == c8dec_pkg::HI_BRBIT) begin
      cls = opcode[0] ? c8dec_pkg::CL_TSTCLR : c8dec_pkg::CL_TSTSET;
      mode = c8dec_pkg::AM_DIR; nbytes = 2'd3; rd_mem = 1'b1;
      len = c8dec_pkg::CYC_BRBIT;
    end else begin
      case (opcode)
        c8dec_pkg::OP_ACC_TO_INDEX: cls = c8dec_pkg::CL_ATOX;
        c8dec_pkg::OP_INDEX_TO_ACC: cls = c8dec_pkg::CL_XTOA;
        c8dec_pkg::OP_HALT:         cls = c8dec_pkg::CL_HALT;
        c8dec_pkg::OP_IDLE:         cls = c8dec_pkg::CL_IDLE;
        default:                    legal = 1'b0;
      endcase
    end
  end
endmodule

// ### core/c8dec_alu.sv
// datapath arithmetic: add with carry, and, shift left, bit set/clear/test
`timescale 1ns/100ps
module c8dec_alu (
  input  c8dec_pkg::c8dec_cls_t cls,
  input  wire logic [7:0]       a,
  input  wire logic [7:0]       m,
  input  wire logic             c_in,
  input  wire logic [2:0]       bitn,
  output logic [7:0]            res,
  output logic                  h_out,
  output logic                  n_out,
  output logic                  z_out,
  output logic                  c_out
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] mask;
  assign sum = {1'b0, a} + {1'b0, m} + {8'h00, c_in};
  assign low_sum = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, c_in};
  assign mask = 8'h01 << bitn;
  always_comb begin
    res = m;
    h_out = low_sum[4];
    c_out = c_in;
    case (cls)
      c8dec_pkg::CL_ADC: begin
        res = sum[7:0];
        c_out = sum[8];
      end
      c8dec_pkg::CL_AND: res = a & m;
      c8dec_pkg::CL_SHL: begin
        res = {m[6:0], 1'b0};
        c_out = m[7];
      end
      c8dec_pkg::CL_BITSET: res = m | mask;
      c8dec_pkg::CL_BITCLR: res = m & ~mask;
      c8dec_pkg::CL_TSTSET, c8dec_pkg::CL_TSTCLR: c_out = m[bitn];
      default: res = m;
    endcase
    n_out = res[7];
    z_out = (res == 8'h00);
  end
endmodule

// ### core/c8dec_core.sv
// cpu8 instruction decoder and sequencer with axi4-lite register access
`timescale 1ns/100ps
module c8dec_core #(
  parameter int ADDR_W = c8dec_pkg::ADDR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic [7:0]             mem_wdata,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic              ext_irq_n,
  output logic                   osc_stop,
  output logic                   cpu_clk_gate
);
  c8dec_pkg::c8dec_state_t state_reg;
  c8dec_pkg::c8dec_cls_t   cls;
  c8dec_pkg::c8dec_mode_t  mode;
  logic [7:0]        a_reg, x_reg, op_reg, b1_reg, b2_reg, m_reg;
  logic [ADDR_W-1:0] pc_reg, ea, pc_target;
  logic              h_reg, i_reg, n_reg, z_reg, c_reg;
  logic [2:0]        cyc_reg, len;
  logic [1:0]        nbytes;
  logic              rd_mem, wr_mem, legal;
  logic              run_reg, illegal_reg, irq_meta_reg, irq_level_reg;
  logic              running, fetch, last, byte_cyc, rd_cyc, wr_cyc;
  logic              cond, taken, idle_st;
  logic [7:0]        b1_now, m_now, alu_in, alu_res, rel;
  logic              alu_h, alu_n, alu_z, alu_c;
  logic              aw_have_reg, w_have_reg, do_write;
  logic [7:0]        awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              wr_hit, rd_hit;

  c8dec_decode u_decode (
    .opcode (op_reg),
    .cls    (cls),
    .mode   (mode),
    .nbytes (nbytes),
    .len    (len),
    .rd_mem (rd_mem),
    .wr_mem (wr_mem),
    .legal  (legal)
  );

  c8dec_alu u_alu (
    .cls   (cls),
    .a     (a_reg),
    .m     (alu_in),
    .c_in  (c_reg),
    .bitn  (op_reg[3:1]),
    .res   (alu_res),
    .h_out (alu_h),
    .n_out (alu_n),
    .z_out (alu_z),
    .c_out (alu_c)
  );

  // interrupt pin is asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_meta_reg <= 1'b1;
      irq_level_reg <= 1'b1;
    end else begin
      irq_meta_reg <= ext_irq_n;
      irq_level_reg <= irq_meta_reg;
    end
  end

  // sequencing: cycle 0 fetches the opcode, then operand bytes, operand
  // read, padding, and the final cycle commits (and writes memory)
  assign running  = (state_reg == c8dec_pkg::ST_RUN);
  assign idle_st  = (state_reg == c8dec_pkg::ST_STOPPED);
  assign fetch    = running && cyc_reg == 3'd0 && run_reg;
  assign last     = running && cyc_reg != 3'd0 && cyc_reg == len - 3'd1;
  assign byte_cyc = running && cyc_reg != 3'd0 && cyc_reg < {1'b0, nbytes};
  assign rd_cyc   = running && rd_mem && cyc_reg == {1'b0, nbytes};
  assign wr_cyc   = last && wr_mem;

  assign b1_now = (cyc_reg == 3'd1) ? mem_rdata : b1_reg;
  always_comb begin
    if (mode == c8dec_pkg::AM_IMM)
      m_now = b1_now;
    else if (rd_cyc)
      m_now = mem_rdata;
    else
      m_now = m_reg;
    case (mode)
      c8dec_pkg::AM_INHA: alu_in = a_reg;
      c8dec_pkg::AM_INHX: alu_in = x_reg;
      default:            alu_in = m_now;
    endcase
  end

  // direct and plain indexed stay in the low 256 bytes
  always_comb begin
    case (mode)
      c8dec_pkg::AM_DIR: ea = {{(ADDR_W-8){1'b0}}, b1_reg};
      c8dec_pkg::AM_EXT: ea = ADDR_W'({b1_reg, b2_reg});
      c8dec_pkg::AM_IX2: ea = ADDR_W'({b1_reg, b2_reg}) + ADDR_W'(x_reg);
      c8dec_pkg::AM_IX1: ea = ADDR_W'(b1_reg) + ADDR_W'(x_reg);
      c8dec_pkg::AM_IX:  ea = {{(ADDR_W-8){1'b0}}, x_reg};
      default:           ea = pc_reg;
    endcase
  end

  assign mem_addr  = (rd_cyc || wr_cyc) ? ea : pc_reg;
  assign mem_rd    = fetch || byte_cyc || rd_cyc;
  assign mem_wr    = wr_cyc;
  assign mem_wdata = alu_res;

  // branch conditions by low nibble of the 2x row
  always_comb begin
    case (op_reg[3:0])
      4'h0: cond = 1'b1;
      4'h2: cond = !(c_reg | z_reg);
      4'h3: cond = c_reg | z_reg;
      4'h4: cond = !c_reg;
      4'h5: cond = c_reg;
      4'h6: cond = !z_reg;
      4'h7: cond = z_reg;
      4'h8: cond = !h_reg;
      4'h9: cond = h_reg;
      4'ha: cond = !n_reg;
      4'hb: cond = n_reg;
      4'hc: cond = !i_reg;
      4'hd: cond = i_reg;
      4'he: cond = !irq_level_reg;
      4'hf: cond = irq_level_reg;
      default: cond = 1'b0;
    endcase
    case (cls)
      c8dec_pkg::CL_BRANCH: taken = cond;
      c8dec_pkg::CL_TSTSET: taken = m_now[op_reg[3:1]];
      c8dec_pkg::CL_TSTCLR: taken = !m_now[op_reg[3:1]];
      default:              taken = 1'b0;
    endcase
  end

  // pc already points past the instruction when the offset is added
  assign rel = (cls == c8dec_pkg::CL_BRANCH) ? b1_reg : b2_reg;
  assign pc_target = pc_reg + ADDR_W'({{8{rel[7]}}, rel});

  always_ff @(posedge aclk) begin
    if (!aresetn)
      pc_reg <= c8dec_pkg::PC_RESET;
    else if (do_write && wr_hit && awaddr_reg == c8dec_pkg::REG_PC && idle_st)
      pc_reg <= ADDR_W'(wdata_reg[15:0]);
    else if (fetch || byte_cyc)
      pc_reg <= pc_reg + ADDR_W'(1);
    else if (last && taken)
      pc_reg <= pc_target;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_reg <= 3'd0;
      op_reg <= 8'h00;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      m_reg <= 8'h00;
    end else begin
      if (!running || last || (cyc_reg == 3'd0 && !run_reg))
        cyc_reg <= 3'd0;
      else
        cyc_reg <= cyc_reg + 3'd1;
      if (fetch)
        op_reg <= mem_rdata;
      if (byte_cyc && cyc_reg == 3'd1)
        b1_reg <= mem_rdata;
      if (byte_cyc && cyc_reg == 3'd2)
        b2_reg <= mem_rdata;
      if (rd_cyc)
        m_reg <= mem_rdata;
    end
  end

  // state: halt and idle wait for the pin to go low, then fetch again
  always_ff @(posedge aclk) begin
    if (!aresetn)
      state_reg <= c8dec_pkg::ST_STOPPED;
    else
      case (state_reg)
        c8dec_pkg::ST_STOPPED:
          if (run_reg)
            state_reg <= c8dec_pkg::ST_RUN;
        c8dec_pkg::ST_RUN:
          if (last && cls == c8dec_pkg::CL_HALT)
            state_reg <= c8dec_pkg::ST_HALT;
          else if (last && cls == c8dec_pkg::CL_IDLE)
            state_reg <= c8dec_pkg::ST_IDLE;
          else if (cyc_reg == 3'd0 && !run_reg)
            state_reg <= c8dec_pkg::ST_STOPPED;
        c8dec_pkg::ST_HALT, c8dec_pkg::ST_IDLE:
          if (!irq_level_reg)
            state_reg <= c8dec_pkg::ST_RUN;
        default:
          state_reg <= c8dec_pkg::ST_STOPPED;
      endcase
  end

  assign osc_stop     = (state_reg == c8dec_pkg::ST_HALT);
  assign cpu_clk_gate = (state_reg == c8dec_pkg::ST_IDLE);

  // accumulator and index register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_reg <= 8'h00;
      x_reg <= 8'h00;
    end else if (do_write && wr_hit && awaddr_reg == c8dec_pkg::REG_AX
                 && idle_st) begin
      if (wstrb_reg[0])
        a_reg <= wdata_reg[7:0];
      if (wstrb_reg[1])
        x_reg <= wdata_reg[15:8];
    end else if (last) begin
      case (cls)
        c8dec_pkg::CL_ADC, c8dec_pkg::CL_AND:
          a_reg <= alu_res;
        c8dec_pkg::CL_SHL: begin
          if (mode == c8dec_pkg::AM_INHA)
            a_reg <= alu_res;
          if (mode == c8dec_pkg::AM_INHX)
            x_reg <= alu_res;
        end
        c8dec_pkg::CL_ATOX: x_reg <= a_reg;
        c8dec_pkg::CL_XTOA: a_reg <= x_reg;
        default: a_reg <= a_reg;
      endcase
    end
  end

  // condition codes: only the flags an instruction lists are written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {h_reg, n_reg, z_reg, c_reg} <= 4'h0;
      i_reg <= 1'b1;
    end else if (do_write && wr_hit && awaddr_reg == c8dec_pkg::REG_AX
                 && idle_st && wstrb_reg[2]) begin
      {h_reg, i_reg, n_reg, z_reg, c_reg} <= wdata_reg[20:16];
    end else if (last) begin
      case (cls)
        c8dec_pkg::CL_ADC:
          {h_reg, n_reg, z_reg, c_reg} <= {alu_h, alu_n, alu_z, alu_c};
        c8dec_pkg::CL_AND:
          {n_reg, z_reg} <= {alu_n, alu_z};
        c8dec_pkg::CL_SHL:
          {n_reg, z_reg, c_reg} <= {alu_n, alu_z, alu_c};
        c8dec_pkg::CL_TSTSET, c8dec_pkg::CL_TSTCLR:
          c_reg <= alu_c;
        c8dec_pkg::CL_HALT, c8dec_pkg::CL_IDLE:
          i_reg <= 1'b0;
        default:
          c_reg <= c_reg;
      endcase
    end
  end

  // axi4-lite slave: address and data are taken in either order
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign do_write      = aw_have_reg && w_have_reg;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_hit = awaddr_reg[7:4] == 4'h0 && awaddr_reg[1:0] == 2'b00;
  assign rd_hit = s_axi_araddr[7:4] == 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= c8dec_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? c8dec_pkg::RESP_OKAY
                              : c8dec_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // run control and sticky illegal-opcode flag (a new event beats a clear)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      if (do_write && wr_hit && awaddr_reg == c8dec_pkg::REG_CTRL
          && wstrb_reg[0])
        run_reg <= wdata_reg[c8dec_pkg::CTRL_RUN_BIT];
      if (last && !legal)
        illegal_reg <= 1'b1;
      else if (do_write && wr_hit && awaddr_reg == c8dec_pkg::REG_STAT
               && wstrb_reg[1] && wdata_reg[c8dec_pkg::STAT_ILLEGAL_BIT])
        illegal_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= c8dec_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rd_hit ? c8dec_pkg::RESP_OKAY : c8dec_pkg::RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'b00})
        c8dec_pkg::REG_CTRL: s_axi_rdata <= {31'h0, run_reg};
        c8dec_pkg::REG_PC:   s_axi_rdata <= 32'(pc_reg);
        c8dec_pkg::REG_AX:
          s_axi_rdata <= {11'h0, h_reg, i_reg, n_reg, z_reg, c_reg,
                          x_reg, a_reg};
        c8dec_pkg::REG_STAT:
          s_axi_rdata <= {23'h0, illegal_reg, 6'h0, state_reg};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### tb/c8dec_asserts.sv
// port checker for the cpu8 decoder core
`timescale 1ns/100ps
module c8dec_asserts #(
  parameter int ADDR_W = 16
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_rd,
  input wire logic              mem_wr,
  input wire logic              ext_irq_n,
  input wire logic              osc_stop,
  input wire logic              cpu_clk_gate
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read response late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_sleep_excl: assert property (!(osc_stop && cpu_clk_gate))
    else $error("halt and idle together");
  a_sleep_quiet: assert property (osc_stop || cpu_clk_gate
    |-> !mem_rd && !mem_wr) else $error("bus busy while asleep");
  a_halt_wake: assert property ((osc_stop && !ext_irq_n) [*3]
    |=> !osc_stop) else $error("halt not left");
  a_idle_wake: assert property ((cpu_clk_gate && !ext_irq_n) [*3]
    |=> !cpu_clk_gate) else $error("idle not left");
  // offset-indexed and plain indexed writes come three cycles after the read
  a_wr_after_rd: assert property (mem_wr |-> (($past(mem_rd, 2) &&
    $past(mem_addr, 2) == mem_addr) || ($past(mem_rd, 3) &&
    $past(mem_addr, 3) == mem_addr)) ##1 !mem_wr)
    else $error("write not paired with read");
  c_halt: cover property (osc_stop);
  c_idle: cover property (cpu_clk_gate);
  c_write: cover property (mem_wr);
endmodule

// ### tb/cpu8_instruction_decoder_tb.sv
// self-checking bench for the cpu8 decoder core
`timescale 1ns/100ps
module cpu8_instruction_decoder_tb;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        ext_irq_n = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, mem_rd, mem_wr;
  logic        osc_stop, cpu_clk_gate;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, mem_wdata, mem_rdata;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] mem_addr;
  logic [7:0]  mem [256] = '{default: 8'h00};
  int          miscompares = 0, checks_done = 0, cyc = 0;
  c8dec_core i_dut (.*);
  always #10 aclk = ~aclk;
  assign mem_rdata = mem[mem_addr[7:0]];
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
               (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 0;
    rr = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic ld(input logic [7:0] a, input logic [7:0] b[]);
    foreach (b[i]) mem[a+i] = b[i];
  endtask
  task automatic cpu_go(input logic [15:0] pc, input logic [20:0] ax);
    axi_wr(c8dec_pkg::REG_PC, {16'h0, pc});
    axi_wr(c8dec_pkg::REG_AX, {11'h0, ax});
    axi_wr(c8dec_pkg::REG_CTRL, 32'h1);
  endtask
  // stop lands on an instruction boundary, so state is read back whole
  task automatic cpu_stop(input logic [15:0] pc, input logic [20:0] ax);
    axi_wr(c8dec_pkg::REG_CTRL, 32'h0);
    repeat (8) @(posedge aclk);
    axi_rd(c8dec_pkg::REG_PC);
    chk(rd, {16'h0, pc});
    axi_rd(c8dec_pkg::REG_AX);
    chk(rd, {11'h0, ax});
  endtask
  task automatic t_adc;
    mem[8'h80] = 8'hc0;
    ld(8'h20, '{8'ha9, 8'h01, 8'hb9, 8'h80, 8'h20, 8'hfe});
    cpu_go(16'h20, 21'h01003f);
    repeat (30) @(posedge aclk);
    cpu_stop(16'h24, 21'h010001);
  endtask
  task automatic t_and_shl;
    mem[8'h81] = 8'h81;
    ld(8'h20, '{8'ha4, 8'h3c, 8'h48, 8'h97, 8'h38, 8'h81, 8'h20, 8'hfe});
    cpu_go(16'h20, 21'h1100f0);
    repeat (40) @(posedge aclk);
    cpu_stop(16'h26, 21'h116060);
    chk(mem[8'h81], 8'h02);
  endtask
  task automatic t_branch;
    logic [7:0] ops [11] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h27,
                             8'h28, 8'h29, 8'h2c, 8'h2d, 8'h2e, 8'h2f};
    logic [4:0] f;
    logic [7:0] r;
    logic       t;
    foreach (ops[i]) for (int k = 0; k < 2; k++) begin
      f = k ? 5'h1f : 5'h00;
      r = k ? 8'hf0 : 8'h10;
      ext_irq_n <= k[0];
      case (ops[i])
        8'h22: t = !(f[0] | f[1]);
        8'h23: t = f[0] | f[1];
        8'h24: t = !f[0];
        8'h25: t = f[0];
        8'h27: t = f[1];
        8'h28: t = !f[4];
        8'h29: t = f[4];
        8'h2c: t = !f[3];
        8'h2d: t = f[3];
        default: t = (ops[i][0] == k[0]);
      endcase
      ld(8'h32, '{8'h20, 8'hfe, 8'h20, 8'hfe});
      ld(8'h40, '{ops[i], r, 8'h20, 8'hfe});
      ld(8'h52, '{8'h20, 8'hfe});
      cpu_go(16'h40, {f, 16'h0});
      repeat (12) @(posedge aclk);
      cpu_stop(t ? 16'h42 + {{8{r[7]}}, r} : 16'h42, {f, 16'h0});
    end
    ext_irq_n <= 1;
  endtask
  task automatic t_bits;
    mem[8'h82] = 8'h00;
    mem[8'h83] = 8'hff;
    ld(8'h60, '{8'h16, 8'h82, 8'h1f, 8'h83, 8'h06, 8'h82, 8'h02,
                8'h20, 8'hfe, 8'h20, 8'hfe});
    cpu_go(16'h60, 21'h0);
    repeat (30) @(posedge aclk);
    cpu_stop(16'h69, 21'h010000);
    chk({mem[8'h82], mem[8'h83]}, 16'h087f);
  endtask
  task automatic t_sleep(input logic [7:0] op);
    ld(8'h70, '{8'h9f, op, 8'h20, 8'hfe});
    cpu_go(16'h70, 21'h085a00);
    repeat (20) @(posedge aclk);
    chk({osc_stop, cpu_clk_gate}, op[0] ? 2'b01 : 2'b10);
    ext_irq_n <= 0;
    repeat (10) @(posedge aclk);
    chk({osc_stop, cpu_clk_gate}, 2'b00);
    ext_irq_n <= 1;
    cpu_stop(16'h72, 21'h005a5a);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    axi_rd(c8dec_pkg::REG_AX);
    chk(rd, 32'h80000);
    axi_rd(8'h10);
    chk({rr, rd[29:0]}, {c8dec_pkg::RESP_SLVERR, 30'h0});
    axi_wr(8'h14, 32'h1);
    chk(rr, c8dec_pkg::RESP_SLVERR);
    t_adc();
    t_and_shl();
    t_branch();
    t_bits();
    t_sleep(c8dec_pkg::OP_HALT);
    t_sleep(c8dec_pkg::OP_IDLE);
    end_of_test();
  end
endmodule
bind c8dec_core c8dec_asserts #(.ADDR_W(ADDR_W)) i_chk (.*);
